// ==== logic/iops_pkg.sv ====
package iops_pkg;
	// bus shape
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	typedef logic [ADDR_W-1:0] iops_addr_t;
	typedef logic [DATA_W-1:0] iops_byte_t;

	// register offsets
	localparam iops_addr_t OFS_VALUE  = 4'h0;
	localparam iops_addr_t OFS_DIR    = 4'h1;
	localparam iops_addr_t OFS_LATCH  = 4'h2;
	localparam iops_addr_t OFS_ANALOG = 4'h3;
	localparam iops_addr_t OFS_STEER0 = 4'h4;
	localparam iops_addr_t OFS_STEER1 = 4'h5;
	localparam iops_addr_t OFS_BITOP  = 4'h6;

	// reset values and write and read masks
	localparam iops_byte_t RST_DIR    = 8'hff;
	localparam iops_byte_t RST_ANS    = 8'h1f;
	localparam iops_byte_t RST_LAT    = 8'h00;
	localparam iops_byte_t RST_STEER  = 8'h00;
	localparam iops_byte_t ANS_MASK   = 8'h1f;
	localparam iops_byte_t LAT_MASK   = 8'hdf;
	localparam iops_byte_t DIR_FORCE  = 8'h20;
	localparam iops_byte_t ZERO_BYTE  = 8'h00;

	// steering bit positions
	localparam int unsigned SEL_RX   = 7;
	localparam int unsigned SEL_SPI1_SERIAL_OUT = 6;
	localparam int unsigned SEL_SS1  = 5;
	localparam int unsigned SEL_P2B  = 4;
	localparam int unsigned SEL_CCP2 = 3;
	localparam int unsigned SEL_P1D  = 2;
	localparam int unsigned SEL_P1C  = 1;
	localparam int unsigned SEL_CCP1 = 0;
	localparam int unsigned SEL_TXCK = 0;

	// pin indices
	localparam int unsigned PIN0 = 0;
	localparam int unsigned PIN1 = 1;
	localparam int unsigned PIN2 = 2;
	localparam int unsigned PIN3 = 3;
	localparam int unsigned PIN5 = 5;
	localparam int unsigned PIN6 = 6;
	localparam int unsigned PIN7 = 7;

	// single-bit write register layout
	localparam int unsigned BITOP_VAL   = 7;
	localparam int unsigned BITOP_IDX_W = 3;
endpackage

// ==== logic/iops_sync.sv ====
`timescale 1ns/100ps
// three-stage input synchroniser; a change counts once stages two and three agree
module iops_sync #(
	parameter int unsigned WIDTH = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// raw and settled levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] settled_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} iops_sync_s;

	iops_sync_s state_reg;
	iops_sync_s state_next;

	// stage one feeds stage two only; the agreement test looks at two and three
	always_comb begin
		state_next    = state_reg;
		state_next.s1 = async_i;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (state_reg.s2[i] == state_reg.s3[i]) begin
				state_next.out[i] = state_reg.s3[i];
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign settled_o = state_reg.out;
endmodule

// ==== logic/iops_port.sv ====
`timescale 1ns/100ps
module iops_port
	import iops_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// register port
	input  wire iops_pkg::iops_addr_t addr_i,
	input  wire iops_pkg::iops_byte_t wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output iops_pkg::iops_byte_t      rdata_o,
	// port A pins
	input  wire logic [7:0] port_a_pin_i,
	output logic      [7:0] port_a_out_o,
	output logic      [7:0] port_a_oe_o,
	output logic      [7:0] port_a_input_en_o,
	// port B pins and its own direction and latch
	input  wire logic [7:0] port_b_pin_i,
	input  wire logic [7:0] port_b_direction_i,
	input  wire logic [7:0] port_b_output_latch_i,
	output logic      [7:0] port_b_out_o,
	output logic      [7:0] port_b_oe_o,
	// peripheral drives: value and enable
	input  wire logic       uart_receive_sync_data_i,
	input  wire logic       uart_receive_sync_data_en_i,
	input  wire logic       uart_transmit_sync_clock_i,
	input  wire logic       uart_transmit_sync_clock_en_i,
	input  wire logic       spi1_serial_out_i,
	input  wire logic       spi1_serial_out_en_i,
	input  wire logic       pwm2_output_b_i,
	input  wire logic       pwm2_output_b_en_i,
	input  wire logic       capture2_pwm2_output_a_i,
	input  wire logic       capture2_pwm2_output_a_en_i,
	input  wire logic       pwm1_output_d_i,
	input  wire logic       pwm1_output_d_en_i,
	input  wire logic       pwm1_output_c_i,
	input  wire logic       pwm1_output_c_en_i,
	input  wire logic       capture1_pwm1_output_a_i,
	input  wire logic       capture1_pwm1_output_a_en_i,
	// steered inputs back to peripherals
	output logic            uart_receive_sync_data_o,
	output logic            spi1_slave_select_o,
	output logic            capture1_in_o,
	output logic            capture2_in_o
);
	import iops_pkg::*;

	typedef struct packed {
		iops_byte_t dir;
		iops_byte_t lat;
		iops_byte_t ans;
		iops_byte_t steer0;
		logic       steer1;
		iops_byte_t rdata;
		iops_byte_t pa_out;
		iops_byte_t pa_oe;
		iops_byte_t pa_ien;
		iops_byte_t pb_out;
		iops_byte_t pb_oe;
		logic       rx;
		logic       ss;
		logic       cap1;
		logic       cap2;
	} iops_state_s;

	iops_state_s state_reg;
	iops_state_s state_next;
	logic [15:0] pins_s;
	iops_byte_t  pa_s;
	iops_byte_t  pb_s;

	// overlay a source on a pin; applied lowest priority first
	function automatic logic [1:0] ovr(input logic hit, input logic v,
		input logic [1:0] cur);
		return hit ? {1'b1, v} : cur;
	endfunction

	// all pin levels come from outside the clock domain
	iops_sync #(
		.WIDTH(16)
	) u_sync (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.async_i  ({port_b_pin_i, port_a_pin_i}),
		.settled_o(pins_s)
	);

	assign pa_s = pins_s[7:0];
	assign pb_s = pins_s[15:8];

	// next-state logic: registers, read data, pin steering
	always_comb begin
		iops_byte_t pa_dig;
		logic [7:0] oa;
		logic [7:0] va;
		logic [7:0] ob;
		logic [7:0] vb;
		pa_dig = '0;
		oa = '0;
		va = '0;
		ob = '0;
		vb = '0;
		state_next = state_reg;
		state_next.pa_ien = ~state_reg.ans;
		pa_dig = pa_s & ~state_reg.ans;

		if (wr_i) begin
			unique case (addr_i)
				OFS_VALUE, OFS_LATCH: state_next.lat = wdata_i;
				OFS_DIR: state_next.dir = wdata_i | DIR_FORCE;
				OFS_ANALOG: state_next.ans = wdata_i & ANS_MASK;
				OFS_STEER0: state_next.steer0 = wdata_i;
				OFS_STEER1: state_next.steer1 = wdata_i[SEL_TXCK];
				OFS_BITOP: begin
					state_next.lat = pa_dig;
					state_next.lat[wdata_i[BITOP_IDX_W-1:0]] = wdata_i[BITOP_VAL];
				end
				default: ;
			endcase
		end

		// read data stands only in the cycle after the strobe
		state_next.rdata = ZERO_BYTE;
		if (rd_i) begin
			unique case (addr_i)
				OFS_VALUE: state_next.rdata = pa_dig;
				OFS_DIR: state_next.rdata = state_reg.dir | DIR_FORCE;
				OFS_LATCH: state_next.rdata = state_reg.lat & LAT_MASK;
				OFS_ANALOG: state_next.rdata = state_reg.ans;
				OFS_STEER0: state_next.rdata = state_reg.steer0;
				OFS_STEER1: state_next.rdata = {7'h00, state_reg.steer1};
				default: state_next.rdata = ZERO_BYTE;
			endcase
		end

		oa = ~state_reg.dir;
		va = state_reg.lat;
		ob = ~port_b_direction_i;
		vb = port_b_output_latch_i;
		oa[PIN5] = 1'b0;

		// pin 6 order pwm2 B, pwm1 D, serial out
		{oa[PIN6], va[PIN6]} = ovr(state_reg.steer0[SEL_P2B] & pwm2_output_b_en_i,
			pwm2_output_b_i, {oa[PIN6], va[PIN6]});
		{ob[PIN7], vb[PIN7]} = ovr(!state_reg.steer0[SEL_P2B] & pwm2_output_b_en_i,
			pwm2_output_b_i, {ob[PIN7], vb[PIN7]});
		{oa[PIN6], va[PIN6]} = ovr(state_reg.steer0[SEL_P1D] & pwm1_output_d_en_i,
			pwm1_output_d_i, {oa[PIN6], va[PIN6]});
		{ob[PIN7], vb[PIN7]} = ovr(!state_reg.steer0[SEL_P1D] & pwm1_output_d_en_i,
			pwm1_output_d_i, {ob[PIN7], vb[PIN7]});
		{oa[PIN6], va[PIN6]} = ovr(state_reg.steer0[SEL_SPI1_SERIAL_OUT] & spi1_serial_out_en_i,
			spi1_serial_out_i, {oa[PIN6], va[PIN6]});
		{ob[PIN2], vb[PIN2]} = ovr(!state_reg.steer0[SEL_SPI1_SERIAL_OUT] & spi1_serial_out_en_i,
			spi1_serial_out_i, {ob[PIN2], vb[PIN2]});
		{oa[PIN7], va[PIN7]} = ovr(state_reg.steer0[SEL_CCP2] &
			capture2_pwm2_output_a_en_i, capture2_pwm2_output_a_i, {oa[PIN7], va[PIN7]});
		{ob[PIN6], vb[PIN6]} = ovr(!state_reg.steer0[SEL_CCP2] &
			capture2_pwm2_output_a_en_i, capture2_pwm2_output_a_i, {ob[PIN6], vb[PIN6]});
		{oa[PIN7], va[PIN7]} = ovr(state_reg.steer0[SEL_P1C] & pwm1_output_c_en_i,
			pwm1_output_c_i, {oa[PIN7], va[PIN7]});
		{ob[PIN6], vb[PIN6]} = ovr(!state_reg.steer0[SEL_P1C] & pwm1_output_c_en_i,
			pwm1_output_c_i, {ob[PIN6], vb[PIN6]});
		{ob[PIN0], vb[PIN0]} = ovr(state_reg.steer0[SEL_CCP1] &
			capture1_pwm1_output_a_en_i, capture1_pwm1_output_a_i, {ob[PIN0], vb[PIN0]});
		{ob[PIN3], vb[PIN3]} = ovr(!state_reg.steer0[SEL_CCP1] &
			capture1_pwm1_output_a_en_i, capture1_pwm1_output_a_i, {ob[PIN3], vb[PIN3]});
		// receive data pin, above serial out
		{ob[PIN1], vb[PIN1]} = ovr(!state_reg.steer0[SEL_RX] &
			uart_receive_sync_data_en_i, uart_receive_sync_data_i, {ob[PIN1], vb[PIN1]});
		{ob[PIN2], vb[PIN2]} = ovr(state_reg.steer0[SEL_RX] &
			uart_receive_sync_data_en_i, uart_receive_sync_data_i, {ob[PIN2], vb[PIN2]});
		// transmit clock pin, top of pin 2
		{ob[PIN2], vb[PIN2]} = ovr(!state_reg.steer1 & uart_transmit_sync_clock_en_i,
			uart_transmit_sync_clock_i, {ob[PIN2], vb[PIN2]});
		{ob[PIN5], vb[PIN5]} = ovr(state_reg.steer1 & uart_transmit_sync_clock_en_i,
			uart_transmit_sync_clock_i, {ob[PIN5], vb[PIN5]});

		state_next.pa_oe = oa;
		state_next.pa_out = va;
		state_next.pb_oe = ob;
		state_next.pb_out = vb;

		state_next.rx = state_reg.steer0[SEL_RX] ? pb_s[PIN2] : pb_s[PIN1];
		state_next.ss = state_reg.steer0[SEL_SS1] ? pa_dig[PIN5] : pb_s[PIN5];
		state_next.cap1 = state_reg.steer0[SEL_CCP1] ? pb_s[PIN0] : pb_s[PIN3];
		state_next.cap2 = state_reg.steer0[SEL_CCP2] ? pa_dig[PIN7] : pb_s[PIN6];
	end

	// state register; latch clears on reset rather than staying unknown
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg        <= '0;
			state_reg.dir    <= RST_DIR;
			state_reg.lat    <= RST_LAT;
			state_reg.ans    <= RST_ANS;
			state_reg.pa_ien <= ~RST_ANS;
			state_reg.steer0 <= RST_STEER;
			state_reg.steer1 <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flops
	assign rdata_o                  = state_reg.rdata;
	assign port_a_out_o             = state_reg.pa_out;
	assign port_a_oe_o              = state_reg.pa_oe;
	assign port_a_input_en_o        = state_reg.pa_ien;
	assign port_b_out_o             = state_reg.pb_out;
	assign port_b_oe_o              = state_reg.pb_oe;
	assign uart_receive_sync_data_o = state_reg.rx;
	assign spi1_slave_select_o      = state_reg.ss;
	assign capture1_in_o            = state_reg.cap1;
	assign capture2_in_o            = state_reg.cap2;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	chk_pin5_no_drive: assert property (!port_a_oe_o[PIN5])
		else $error("input-only pin driven");
	chk_dir_gates_oe: assert property (##1 port_a_oe_o[4:0] == ~$past(state_reg.dir[4:0])
		&& port_a_out_o[4:0] == $past(state_reg.lat[4:0]))
		else $error("plain pin driver wrong");
	chk_dir_read_one: assert property (rd_i && addr_i == OFS_DIR |=> rdata_o[PIN5])
		else $error("pin 5 direction read zero");
	chk_latch_write: assert property (wr_i && (addr_i == OFS_LATCH || addr_i == OFS_VALUE)
		|=> state_reg.lat == $past(wdata_i))
		else $error("latch not written");
	chk_latch_read: assert property (rd_i && addr_i == OFS_LATCH
		|=> rdata_o == ($past(state_reg.lat) & LAT_MASK))
		else $error("latch readback wrong");
	chk_analog_zero: assert property (rd_i && addr_i == OFS_VALUE
		|=> (rdata_o & $past(state_reg.ans)) == ZERO_BYTE)
		else $error("analog pin read nonzero");
	chk_steer_keeps_dir: assert property (wr_i && addr_i == OFS_STEER0
		|=> $stable(state_reg.dir))
		else $error("steering changed direction");
	chk_rx_pin_route: assert property (##1 uart_receive_sync_data_o ==
		($past(state_reg.steer0[SEL_RX]) ? $past(pb_s[PIN2]) : $past(pb_s[PIN1])))
		else $error("receive data from wrong pin");
	chk_spi1_serial_out_top_ra6: assert property (state_reg.steer0[SEL_SPI1_SERIAL_OUT] && spi1_serial_out_en_i
		|=> port_a_oe_o[PIN6] && port_a_out_o[PIN6] == $past(spi1_serial_out_i))
		else $error("serial out lost pin 6");
	chk_steer1_upper: assert property (rd_i && addr_i == OFS_STEER1
		|=> rdata_o[7:1] == 7'h00)
		else $error("steer1 upper bits nonzero");
	chk_ien_follows: assert property (##1 port_a_input_en_o == ~$past(state_reg.ans))
		else $error("input buffer enable wrong");
endmodule

// ==== tb/iops_pins_model.sv ====
`timescale 1ns/100ps
// far side: each pad follows the device drive where enabled, else the outside level
module iops_pins_model (
	// device drive
	input  wire logic [7:0] a_out_i,
	input  wire logic [7:0] a_oe_i,
	input  wire logic [7:0] b_out_i,
	input  wire logic [7:0] b_oe_i,
	// outside levels
	input  wire logic [7:0] a_ext_i,
	input  wire logic [7:0] b_ext_i,
	// resolved pad levels
	output logic      [7:0] a_pin_o,
	output logic      [7:0] b_pin_o
);
	// a released pad shows the outside source, never a stale device value
	assign a_pin_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ext_i);
	assign b_pin_o = (b_oe_i & b_out_i) | (~b_oe_i & b_ext_i);
endmodule

// ==== tb/iops_port_tb.sv ====
`timescale 1ns/100ps
module iops_port_tb;
	import iops_pkg::*;
	logic       clk, reset_i, wr, rd, rx_o, ss_o, c1_o, c2_o;
	iops_addr_t addr;
	iops_byte_t wdata, rdata;
	logic [7:0] a_pin, a_out, a_oe, a_ien, b_pin, b_out, b_oe, b_dir, b_lat, a_ext, b_ext;
	logic [7:0] p_val, p_en;
	logic [15:0] o;
	logic [3:0] pos;
	int         error_cnt, n_compared;
	// pad codes: bit 3 marks port A, bits 2:0 the pin; order rx tx sdo p2b cap2 p1d p1c cap1
	logic [3:0] pin0[8] = '{4'h1, 4'h2, 4'h2, 4'h7, 4'h6, 4'h7, 4'h6, 4'h3};
	logic [3:0] pin1[8] = '{4'h2, 4'h5, 4'he, 4'he, 4'hf, 4'he, 4'hf, 4'h0};
	int         sbit[8] = '{7, 0, 6, 4, 3, 2, 1, 0};
	logic [7:0] pr_en[3] = '{8'h24, 8'h20, 8'h00};

	iops_port iops_port_i (.clk_i(clk), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .port_a_pin_i(a_pin), .port_a_out_o(a_out),
		.port_a_oe_o(a_oe), .port_a_input_en_o(a_ien), .port_b_pin_i(b_pin),
		.port_b_direction_i(b_dir), .port_b_output_latch_i(b_lat), .port_b_out_o(b_out),
		.port_b_oe_o(b_oe), .uart_receive_sync_data_i(p_val[0]),
		.uart_receive_sync_data_en_i(p_en[0]), .uart_transmit_sync_clock_i(p_val[1]),
		.uart_transmit_sync_clock_en_i(p_en[1]), .spi1_serial_out_i(p_val[2]),
		.spi1_serial_out_en_i(p_en[2]), .pwm2_output_b_i(p_val[3]),
		.pwm2_output_b_en_i(p_en[3]), .capture2_pwm2_output_a_i(p_val[4]),
		.capture2_pwm2_output_a_en_i(p_en[4]), .pwm1_output_d_i(p_val[5]),
		.pwm1_output_d_en_i(p_en[5]), .pwm1_output_c_i(p_val[6]),
		.pwm1_output_c_en_i(p_en[6]), .capture1_pwm1_output_a_i(p_val[7]),
		.capture1_pwm1_output_a_en_i(p_en[7]), .uart_receive_sync_data_o(rx_o),
		.spi1_slave_select_o(ss_o), .capture1_in_o(c1_o), .capture2_in_o(c2_o));

	iops_pins_model iops_pins_model_i (.a_out_i(a_out), .a_oe_i(a_oe), .b_out_i(b_out),
		.b_oe_i(b_oe), .a_ext_i(a_ext), .b_ext_i(b_ext), .a_pin_o(a_pin), .b_pin_o(b_pin));

	// clock: 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input iops_addr_t a, input iops_byte_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the read edge
	task automatic rd_chk(input iops_addr_t a, input iops_byte_t exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		// the edge above took the strobe; the data stand until the next edge
		#1;
		check(16'(rdata), 16'(exp));
	endtask

	task automatic do_reset();
		reset_i <= 1'b1;
		repeat (6) @(posedge clk);
		reset_i <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	initial begin
		{reset_i, wr, rd, addr, wdata} = '1;
		{wr, rd, addr, wdata, p_val, p_en} = '0;
		{b_dir, b_lat, a_ext, b_ext} = {8'hff, 8'h00, 8'h00, 8'h00};
		do_reset();
		rd_chk(OFS_DIR, 8'hff);
		rd_chk(OFS_LATCH, 8'h00);
		rd_chk(OFS_ANALOG, 8'h1f);
		rd_chk(OFS_STEER0, 8'h00);
		rd_chk(OFS_STEER1, 8'h00);
		rd_chk(4'hf, 8'h00);
		// every steered output on both candidate pads, the other pad left alone
		for (int f = 0; f < 8; f++) begin
			for (int s = 0; s < 2; s++) begin
				wr_reg(f == 1 ? OFS_STEER1 : OFS_STEER0, iops_byte_t'(s << sbit[f]));
				p_en <= 8'h01 << f;
				p_val <= {8{s[0] ^ f[0]}};
				repeat (2) @(posedge clk);
				#1;
				pos = s ? pin1[f] : pin0[f];
				o = {a_out, b_out};
				check({a_oe, b_oe}, 16'h0001 << pos);
				check(16'(o[pos]), 16'(s[0] ^ f[0]));
			end
		end
		@(posedge clk);
		p_en <= 8'h00;
		rd_chk(OFS_DIR, 8'hff);
		// steered inputs follow the selected pads
		wr_reg(OFS_STEER0, 8'h00);
		b_ext <= 8'h62;
		repeat (6) @(posedge clk);
		check(16'({rx_o, ss_o, c1_o, c2_o}), 16'hd);
		wr_reg(OFS_STEER0, 8'hff);
		b_ext <= 8'h01;
		a_ext <= 8'h20;
		repeat (6) @(posedge clk);
		check(16'({rx_o, ss_o, c1_o, c2_o}), 16'h6);
		// drivers on, analog still selected
		wr_reg(OFS_DIR, 8'h00);
		wr_reg(OFS_LATCH, 8'ha5);
		repeat (2) @(posedge clk);
		#1;
		check(16'(a_oe), 16'hdf);
		check(16'(a_out & a_oe), 16'h85);
		rd_chk(OFS_DIR, 8'h20);
		rd_chk(OFS_LATCH, 8'h85);
		// two sources and the latch compete for port A pin 6
		wr_reg(OFS_LATCH, 8'h40);
		wr_reg(OFS_STEER0, 8'h44);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			p_en <= pr_en[k];
			p_val <= 8'h04;
			repeat (2) @(posedge clk);
			#1;
			check(16'(a_out[6]), 16'(k != 1));
		end
		wr_reg(OFS_STEER0, 8'h00);
		// value write lands in the latch; analog pads read zero
		wr_reg(OFS_VALUE, 8'h3c);
		rd_chk(OFS_LATCH, 8'h1c);
		repeat (6) @(posedge clk);
		rd_chk(OFS_VALUE, 8'h20);
		check(16'(a_ien), 16'he0);
		wr_reg(OFS_ANALOG, 8'h00);
		repeat (6) @(posedge clk);
		rd_chk(OFS_VALUE, 8'h3c);
		check(16'(a_ien), 16'hff);
		// single-bit writes read the pads, then modify
		wr_reg(OFS_DIR, 8'hff);
		a_ext <= 8'h5a;
		repeat (6) @(posedge clk);
		wr_reg(OFS_BITOP, 8'h80);
		rd_chk(OFS_LATCH, 8'h5b);
		wr_reg(OFS_BITOP, 8'h03);
		rd_chk(OFS_LATCH, 8'h52);
		// steering clears on a reset in mid-run
		wr_reg(OFS_STEER0, 8'hff);
		wr_reg(OFS_STEER1, 8'hff);
		rd_chk(OFS_STEER1, 8'h01);
		@(posedge clk);
		do_reset();
		rd_chk(OFS_STEER0, 8'h00);
		rd_chk(OFS_STEER1, 8'h00);
		print_verdict();
	end
endmodule
